//--- design/mbd_pkg.sv
package mbd_pkg;
  // Density codes
  localparam logic [7:0] DENS_LEGACY_LO = 8'h14;
  localparam logic [7:0] DENS_UNC_HI = 8'h15;
  localparam logic [7:0] DENS_CMP_HI = 8'h8c;
  localparam logic [7:0] DENS_CMP_LO = 8'h90;
  localparam logic [7:0] DENS_DEFAULT = 8'h00;
  localparam logic [7:0] DENS_KEEP = 8'h7f;
  // Descriptor layout
  localparam logic [7:0] DESC_LEN = 8'h08;
  localparam logic [7:0] DESC_NONE = 8'h00;
  localparam logic [2:0] BYTE_DENS = 3'h0;
  localparam logic [2:0] BYTE_CNT_HI = 3'h1;
  localparam logic [2:0] BYTE_CNT_MID = 3'h2;
  localparam logic [2:0] BYTE_CNT_LO = 3'h3;
  localparam logic [2:0] BYTE_RSVD = 3'h4;
  localparam logic [2:0] BYTE_LEN_HI = 3'h5;
  localparam logic [2:0] BYTE_LEN_MID = 3'h6;
  localparam logic [2:0] BYTE_LEN_LO = 3'h7;
  // Reset values
  localparam logic [23:0] LEN_RESET = 24'h000400;
  localparam logic [23:0] MAX_LEN_RESET = 24'h03c000;
  // APB register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CAPACITY = 8'h08;
  localparam logic [7:0] ADDR_MAXLEN = 8'h0c;
  localparam logic [7:0] ADDR_DESC_LO = 8'h10;
  localparam logic [7:0] ADDR_DESC_HI = 8'h14;
  localparam logic [7:0] ADDR_FORMATS = 8'h18;
  // Control register fields
  localparam int CTRL_SUPPRESS = 0;
  // Density source
  typedef enum logic [1:0]
  {
    MBD_SRC_WRITE = 2'b00,
    MBD_SRC_READ = 2'b01,
    MBD_SRC_BLANK = 2'b10
  } mbd_src_t;
endpackage

//--- design/mbd_top.sv
`timescale 1ns/1ns
// Summary of operation
// - Same eight-byte descriptor for both formats
// - Density code follows most recent activity
// - Power-on, select, write report write format unless blank tape loaded
// - Loaded written tape, read report recorded format
// - Only non-keep-current select or append changes write format
// - Blank tape loaded reports compressed high density
// - Unloaded, unknown, not ready report write density
// - Appending adopts tape format as the write format
// - Density encodings 14h, 15h, 8Ch, 90h
// - Density zero means compressed high density
// - Block count is capacity in kilobyte blocks
// - Zero length means variable length blocks
// - Block length resets to 1024 bytes
// - Select never sets block length above reported maximum
// - Read/write format fields ignore last activity
// - Descriptor length field is zero or eight
module mbd_top
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Tape status levels and command events; events are one-cycle pulses from drive logic
  input wire logic loadDone,
  input wire logic loadBlank,
  input wire logic unloadDone,
  input wire logic tapeReady,
  input wire logic [7:0] tapeFormat,
  input wire logic formatKnown,
  input wire logic [23:0] tapeCapacity,
  input wire logic readCmd,
  input wire logic writeCmd,
  input wire logic appendCmd,
  input wire logic selectCmd,
  input wire logic [7:0] selectDensity,
  input wire logic selectLenValid,
  input wire logic [23:0] selectLength,
  // Descriptor byte port
  input wire logic [2:0] descIndex,
  output logic [7:0] descByte,
  output logic [7:0] descLength,
  output logic [7:0] densityCode,
  output logic [23:0] blockLength,
  output logic variableMode,
  output logic selectRejected
);

  // All block state except the reset release chain in one record; one comb copy feeds one flop bank.
  // Keeping everything in one struct keeps reset and update in one place,
  // at the cost of every field being rewritten on every clock.
  typedef struct packed
  {
    // Bus answer; ready and error live for one cycle, data holds
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    // Header reports no descriptor when set
    logic suppress;
    // Format chosen for writing
    logic [7:0] writeFmt;
    // Format found on the loaded tape
    logic [7:0] readFmt;
    // Which activity last decided the reported density
    logic [1:0] src;
    // Logical block length, zero for variable
    logic [23:0] blkLen;
    // Ceiling that a select length may not pass
    logic [23:0] maxLen;
    // Registered descriptor byte
    logic [7:0] byteOut;
    // Registered density code
    logic [7:0] dens;
    // Registered descriptor length field
    logic [7:0] descLen;
    // Registered variable-length flag
    logic varMode;
    // Oversize length refused this cycle
    logic reject;
  } mbd_state_t;

  // Reset release chain
  logic [1:0] rstSync;
  // Released reset for the rest of the block
  logic rstSyncB;
  // Current state
  mbd_state_t st_reg;
  // Next state
  mbd_state_t st_next;
  // Density the descriptor shows right now
  logic [7:0] curDens;
  // Select density with the default code folded in
  logic [7:0] selDensNorm;
  // Whole descriptor, byte 0 in the top bits
  logic [63:0] descWord;

  // Map density zero onto the native compressed format.
  // Used for both select data and the recorded format, so that
  // older hosts asking for the default see the real code back.
  function automatic logic [7:0] mbd_norm(input logic [7:0] d);
    mbd_norm = (d == mbd_pkg::DENS_DEFAULT) ? mbd_pkg::DENS_CMP_HI : d;
  endfunction

  // Reset release through two flops; assert is immediate.
  // The pin may rise at any moment relative to the clock, so the
  // release is retimed to avoid part of the state leaving reset
  // one cycle before the rest.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      rstSync <= 2'b00;
    else
      rstSync <= {rstSync[0], 1'b1};
  end
  assign rstSyncB = rstSync[1];

  // Select density as it would be stored
  assign selDensNorm = mbd_norm(selectDensity);

  // Density reported now, from the activity source.
  // Read source shows the tape, write source the chosen format,
  // blank source always the native compressed code.
  // Code 2'b11 never occurs; it falls back to the write format.
  always_comb
  begin
    unique case (mbd_pkg::mbd_src_t'(st_reg.src))
      mbd_pkg::MBD_SRC_READ:
        curDens = st_reg.readFmt;
      mbd_pkg::MBD_SRC_BLANK:
        curDens = mbd_pkg::DENS_CMP_HI;
      mbd_pkg::MBD_SRC_WRITE:
        curDens = st_reg.writeFmt;
      default:
        curDens = st_reg.writeFmt;
    endcase
  end

  // Descriptor image, most significant bytes first; reserved byte zero.
  // Capacity comes live from the drive, so it is never stale.
  // Both page and non-page answers use this one image.
  assign descWord = {curDens, tapeCapacity, 8'h00, st_reg.blkLen};

  // Next-state logic.
  // Starts from the held state and applies, in order: activity
  // tracking, select data, the not-ready override, the output
  // copies and the bus access. Pulses clear every cycle.
  // Events are expected one at a time; when two coincide the
  // later one in this list wins, save that a finishing load beats not ready; this keeps the outcome defined
  // without extra arbitration logic.
  always_comb
  begin
    st_next = st_reg;
    st_next.ready = 1'b0;
    st_next.slverr = 1'b0;
    st_next.reject = 1'b0;
    // Activity tracking; later events in a cycle take priority.
    // Blank mode is sticky until unload, a new load or not ready.
    // Unload returns to the write format
    if (unloadDone)
    begin
      st_next.src = mbd_pkg::MBD_SRC_WRITE;
    end
    // Load end decides between blank, known and unknown recordings
    if (loadDone)
    begin
      if (loadBlank)
        st_next.src = mbd_pkg::MBD_SRC_BLANK;
      else if (formatKnown)
      begin
        st_next.src = mbd_pkg::MBD_SRC_READ;
        st_next.readFmt = mbd_norm(tapeFormat);
      end
      else
        st_next.src = mbd_pkg::MBD_SRC_WRITE;
    end
    if (readCmd && st_reg.src != mbd_pkg::MBD_SRC_BLANK)
    begin
      // Unknown recordings keep reporting the write density
      if (formatKnown)
        st_next.src = mbd_pkg::MBD_SRC_READ;
    end
    // Write shows the write format unless the tape is blank
    if (writeCmd)
    begin
      if (st_reg.src != mbd_pkg::MBD_SRC_BLANK)
        st_next.src = mbd_pkg::MBD_SRC_WRITE;
      // Append adopts the recorded format as the write format
      if (appendCmd && formatKnown)
        st_next.writeFmt = st_reg.readFmt;
    end
    // Select may change format, length, or both
    if (selectCmd)
    begin
      if (st_reg.src != mbd_pkg::MBD_SRC_BLANK)
        st_next.src = mbd_pkg::MBD_SRC_WRITE;
      if (selectDensity != mbd_pkg::DENS_KEEP)
        st_next.writeFmt = selDensNorm;
      if (selectLenValid)
      begin
        // Oversize lengths are refused and the old length stays
        if (selectLength <= st_reg.maxLen)
          st_next.blkLen = selectLength;
        else
          st_next.reject = 1'b1;
      end
    end
    // Not ready overrides all, except a load finishing now;
    // the drive may drop ready for a cycle while threading.
    if (!tapeReady && !loadDone)
      st_next.src = mbd_pkg::MBD_SRC_WRITE;
    // Registered byte and density outputs.
    // Both lag their inputs by one clock.
    st_next.byteOut = descWord[(7 - descIndex) * 8 +: 8];
    st_next.dens = curDens;
    // APB access phase, single-wait answer.
    // The ready flag blocks a second take of the same access,
    // since the master still holds the request while ready shows.
    // Read data is cleared first so unmapped reads return zero.
    if (psel && penable && !st_reg.ready)
    begin
      st_next.ready = 1'b1;
      st_next.rdata = 32'h00000000;
      unique case (paddr)
        // Control: descriptor suppress bit
        mbd_pkg::ADDR_CTRL:
          if (pwrite)
            st_next.suppress = pwdata[mbd_pkg::CTRL_SUPPRESS];
          else
            st_next.rdata = {31'h0, st_reg.suppress};
        // Status: source and density, read only
        mbd_pkg::ADDR_STATUS:
          st_next.rdata = {22'h0, st_reg.src, curDens};
        // Capacity in kilobyte blocks, read only
        mbd_pkg::ADDR_CAPACITY:
          st_next.rdata = {8'h00, tapeCapacity};
        // Length ceiling, read and write
        mbd_pkg::ADDR_MAXLEN:
          if (pwrite)
            st_next.maxLen = pwdata[23:0];
          else
            st_next.rdata = {8'h00, st_reg.maxLen};
        // Descriptor bytes 4 to 7
        mbd_pkg::ADDR_DESC_LO:
          st_next.rdata = descWord[31:0];
        // Descriptor bytes 0 to 3
        mbd_pkg::ADDR_DESC_HI:
          st_next.rdata = descWord[63:32];
        // Write and read formats, independent of activity
        mbd_pkg::ADDR_FORMATS:
          st_next.rdata = {16'h0, st_reg.writeFmt, st_reg.readFmt};
        default:
          st_next.slverr = 1'b1;
      endcase
    end
    // Decoded outputs are registered too, so pins come from flops
    st_next.descLen = st_next.suppress ? mbd_pkg::DESC_NONE : mbd_pkg::DESC_LEN;
    st_next.varMode = (st_next.blkLen == 24'h000000);
  end

  // State register.
  // Reset loads the power-on write format and lengths, the density code and
  // the descriptor length; every other field starts at zero, which keeps the bus quiet.
  always_ff @(posedge clock or negedge rstSyncB)
  begin
    if (!rstSyncB)
    begin
      st_reg <= '0;
      st_reg.writeFmt <= mbd_pkg::DENS_CMP_HI;
      st_reg.src <= mbd_pkg::MBD_SRC_WRITE;
      st_reg.blkLen <= mbd_pkg::LEN_RESET;
      st_reg.maxLen <= mbd_pkg::MAX_LEN_RESET;
      st_reg.dens <= mbd_pkg::DENS_CMP_HI;
      st_reg.descLen <= mbd_pkg::DESC_LEN;
    end
    else
      st_reg <= st_next;
  end

  // Outputs straight from flops.
  // No logic sits between a flop and a pin, so outputs never glitch.
  // The decoded fields are computed one step earlier instead.
  always_comb
  begin
    prdata = st_reg.rdata;
    pready = st_reg.ready;
    pslverr = st_reg.slverr;
    descByte = st_reg.byteOut;
    descLength = st_reg.descLen;
    densityCode = st_reg.dens;
    blockLength = st_reg.blkLen;
    variableMode = st_reg.varMode;
    selectRejected = st_reg.reject;
  end

endmodule

//--- dv/mbd_chk.sv
`timescale 1ns/1ns
module mbd_chk
(
  // Watched ports
  input wire logic clock,
  input wire logic rst_b,
  input wire logic loadDone,
  input wire logic loadBlank,
  input wire logic tapeReady,
  input wire logic [2:0] descIndex,
  input wire logic [7:0] descByte,
  input wire logic [7:0] descLength,
  input wire logic [7:0] densityCode,
  input wire logic [23:0] blockLength,
  input wire logic variableMode,
  input wire logic selectRejected
);
  // One domain
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // Blank tape load
  sequence s_blank; loadDone && loadBlank && tapeReady; endsequence
  property p_blank; s_blank |-> ##2 densityCode == 8'h8c; endproperty
  property p_den; densityCode inside {8'h14, 8'h15, 8'h8c, 8'h90}; endproperty
  property p_vm; variableMode == (blockLength == 24'h0); endproperty
  property p_dl; descLength == 8'h08 || descLength == 8'h00; endproperty
  property p_rsvd; descIndex == 3'h4 |=> descByte == 8'h00; endproperty
  property p_len; descIndex == 3'h7 |=> descByte == $past(blockLength[7:0]); endproperty
  property p_rej; selectRejected |-> $stable(blockLength); endproperty
  property p_rst; $rose(rst_b) |-> (blockLength == 24'h000400) [*2]; endproperty
  a_blank: assert property (p_blank) else $error("blank density");
  a_den: assert property (p_den) else $error("bad density");
  a_vm: assert property (p_vm) else $error("mode flag");
  a_dl: assert property (p_dl) else $error("desc length");
  a_rsvd: assert property (p_rsvd) else $error("reserved byte");
  a_len: assert property (p_len) else $error("length byte");
  a_rej: assert property (p_rej) else $error("rejected length");
  a_rst: assert property (p_rst) else $error("reset length");
endmodule
bind mbd_top mbd_chk i_mbd_chk (.*);

//--- dv/mbd_initiator.sv
`timescale 1ns/1ns
module mbd_initiator
(
  // Request code, zero when idle
  input wire logic [2:0] op,
  // Events: load, unload, read, write, select
  output logic [4:0] ev
);
  // One event per request, never two at once
  assign ev = 5'(op != 3'h0) << (op - 3'h1);
endmodule

//--- dv/mode_block_descriptor_gen_test.sv
`timescale 1ns/1ns
module mode_block_descriptor_gen_test;
  // Stimulus, observed outputs, expectations
  logic clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic loadBlank = 1'b0, tapeReady = 1'b1, appendCmd = 1'b0, selectLenValid = 1'b0;
  logic formatKnown = 1'b1, rejSeen = 1'b0;
  logic [7:0] paddr = 8'h0, tapeFormat = 8'h0, selectDensity = 8'h0, descByte, descLength, densityCode, wf;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [23:0] tapeCapacity = 24'h0, selectLength = 24'h0, blockLength, len, bl;
  logic [2:0] descIndex = 3'h0, op = 3'h0;
  logic [4:0] pe;
  logic [7:0] tbl [6] = '{8'h15, 8'h7f, 8'h00, 8'h14, 8'h7f, 8'h90};
  logic [63:0] q;
  logic pready, pslverr, variableMode, selectRejected;
  int error_cnt = 0, n_checks = 0, dummy;
  initial forever #2 clock = ~clock;
  mbd_initiator i_mbd_initiator (.op, .ev(pe));
  mbd_top i_mbd_top (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .loadDone(pe[0]), .loadBlank, .unloadDone(pe[1]), .tapeReady, .tapeFormat, .formatKnown,
    .tapeCapacity, .readCmd(pe[2]), .writeCmd(pe[3]), .appendCmd, .selectCmd(pe[4]), .selectDensity,
    .selectLenValid, .selectLength, .descIndex, .descByte, .descLength, .densityCode, .blockLength,
    .variableMode, .selectRejected);
  // Rejection pulse is one cycle wide; latch it for a later compare
  always @(posedge clock)
    if (selectRejected === 1'b1)
      rejSeen <= 1'b1;
  // Write format after a select; keep code leaves it
  function automatic logic [7:0] want(input logic [7:0] c, old);
    return (c == 8'h7f) ? old : (c == 8'h00) ? 8'h8c : c;
  endfunction
  task chk(input logic [31:0] s, x);
    n_checks++;
    error_cnt += (s !== x);
    if (s !== x) $display("wrong value at %0t: saw %h want %h", $time, s, x);
  endtask
  // Event pulse, then room for the two-edge lag
  task ev(input logic [2:0] o);
    op <= o;
    @(posedge clock);
    op <= 3'h0;
    repeat (3) @(posedge clock);
  endtask
  // APB transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge clock);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard, far beyond the run length
  initial
  begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    end_sim();
  end
  initial
  begin
    dummy = $urandom(10);
    tapeCapacity <= 24'($urandom);
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    apb(1'b0, mbd_pkg::ADDR_STATUS, 32'h0);
    chk(r[7:0], 8'h8c);
    apb(1'b0, mbd_pkg::ADDR_MAXLEN, 32'h0);
    chk(r, 32'h0003c000);
    apb(1'b0, 8'h1c, 32'h0);
    chk(e, 1'b1);
    chk(blockLength, 24'h000400);
    apb(1'b0, mbd_pkg::ADDR_CAPACITY, 32'h0);
    chk(r, {8'h00, tapeCapacity});
    $display("reset test done");
    {wf, bl} = {8'h8c, 24'h000400};
    for (int i = 0; i < 6; i++)
    begin
      len = (i == 2) ? 24'h0 : (i == 5) ? 24'h03c001 : 24'($urandom % 32'h3c001);
      {selectDensity, selectLength, selectLenValid} <= {tbl[i], len, 1'b1};
      wf = want(tbl[i], wf);
      bl = (len > 24'h03c000) ? bl : len;
      ev(3'h5);
      chk(densityCode, wf);
      chk(blockLength, bl);
      chk(variableMode, bl == 24'h0);
    end
    chk(rejSeen, 1'b1);
    tapeFormat <= 8'h15;
    ev(3'h1);
    chk(densityCode, 8'h15);
    ev(3'h4);
    chk(densityCode, wf);
    ev(3'h3);
    chk(densityCode, 8'h15);
    apb(1'b0, mbd_pkg::ADDR_FORMATS, 32'h0);
    chk(r[15:0], {wf, 8'h15});
    tapeReady <= 1'b0;
    repeat (4) @(posedge clock);
    chk(densityCode, wf);
    {tapeReady, appendCmd} <= 2'b11;
    ev(3'h4);
    appendCmd <= 1'b0;
    ev(3'h4);
    chk(densityCode, 8'h15);
    ev(3'h2);
    loadBlank <= 1'b1;
    ev(3'h1);
    {loadBlank, selectDensity, selectLenValid} <= {1'b0, 8'h14, 1'b0};
    ev(3'h5);
    chk(densityCode, 8'h8c);
    $display("density test done");
    q = {8'h8c, tapeCapacity, 8'h00, bl};
    for (int i = 0; i < 8; i++)
    begin
      descIndex <= 3'(i);
      repeat (2) @(posedge clock);
      chk(descByte, q[63 - 8 * i -: 8]);
    end
    apb(1'b0, mbd_pkg::ADDR_DESC_HI, 32'h0);
    chk(r, q[63:32]);
    apb(1'b0, mbd_pkg::ADDR_DESC_LO, 32'h0);
    chk(r, q[31:0]);
    apb(1'b1, mbd_pkg::ADDR_CTRL, 32'h1);
    chk(descLength, 8'h00);
    apb(1'b1, mbd_pkg::ADDR_CTRL, 32'h0);
    chk(descLength, 8'h08);
    $display("descriptor test done");
    ev(3'h2);
    formatKnown <= 1'b0;
    ev(3'h1);
    chk(densityCode, 8'h14);
    ev(3'h3);
    chk(densityCode, 8'h14);
    formatKnown <= 1'b1;
    $display("unknown format test done");
    end_sim();
  end
endmodule
